// ### logic/lcs_pkg.sv
// Package of offsets, fields, reset values and timing constants for the link control block.
package lcs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LINK_CTL_STS = 8'hf0;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'hf8;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'hfc;
    localparam logic [7:0] ADDR_PORT_CFG     = 8'he8;

    // ------------------------------------------------------------------
    // Link control fields
    // ------------------------------------------------------------------
    localparam int ASPM_LO      = 0;
    localparam int ASPM_HI      = 1;
    localparam int RCB_BIT      = 3;
    localparam int LINK_DIS_BIT = 4;
    localparam int RETRAIN_BIT  = 5;
    localparam int COM_CLK_BIT  = 6;
    localparam int EXT_SYNC_BIT = 7;

    localparam logic [1:0] ASPM_OFF    = 2'h0;
    localparam logic [1:0] ASPM_L0S    = 2'h1;
    localparam logic [1:0] ASPM_L1     = 2'h2;
    localparam logic [1:0] ASPM_BOTH   = 2'h3;

    // ------------------------------------------------------------------
    // Link status fields
    // ------------------------------------------------------------------
    localparam int SPEED_LO     = 16;
    localparam int SPEED_HI     = 19;
    localparam int WIDTH_LO     = 20;
    localparam int WIDTH_HI     = 25;
    localparam int TRN_ERR_BIT  = 26;
    localparam int TRAINING_BIT = 27;
    localparam int SLOT_CLK_BIT = 28;
    localparam int DL_ACT_BIT   = 29;

    localparam logic [3:0] SPEED_2G5   = 4'h1;
    localparam logic [5:0] WIDTH_RESET = 6'h01;

    // ------------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------------
    localparam int IRQ_W          = 4;
    localparam int IRQ_TRN_DONE   = 0;
    localparam int IRQ_TRN_ERR    = 1;
    localparam int IRQ_DL_UP      = 2;
    localparam int IRQ_DL_DOWN    = 3;

    // ------------------------------------------------------------------
    // Ordered set counts for extended synchronisation
    // ------------------------------------------------------------------
    localparam logic [12:0] FTS_NORMAL = 13'h00ff;
    localparam logic [12:0] FTS_EXT    = 13'h1000;
    localparam logic [12:0] TS1_NORMAL = 13'h0010;
    localparam logic [12:0] TS1_EXT    = 13'h0400;

endpackage : lcs_pkg

// ### logic/lcs_wb_slave.sv
// Classic Wishbone slave front end: one-cycle ack, decoded strobes.
`timescale 1ns/1ns
module lcs_wb_slave (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Wishbone
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    output logic             wb_ack_o,
    // Strobes to the register file
    output logic             wrStb,
    output logic             rdStb
);

    logic reqLive;

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    // Ack is registered and lasts one cycle; a held request is masked in the ack cycle and retaken in the cycle after.
    assign reqLive = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrStb   = reqLive & wb_we_i;
    assign rdStb   = reqLive & ~wb_we_i;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= reqLive;
        end
    end

endmodule : lcs_wb_slave

// ### logic/lcs_link_control_status.sv
// Link control and link status register bank of one PCI Express port.
//
// Contract
// - ASPM field 00 off,01 L0s,10 L1,11 both
// - Receiver L0s entry always allowed
// - Read completion boundary bit reads zero
// - Link disable downstream only; upstream hardwired zero
// - Retrain downstream only; always reads zero
// - Common clock bit read-write, resets zero
// - Extended sync: 4096 FTS, 1024 TS1
// - Link speed reads 0001b
// - Negotiated width reported in bits 25:20
// - Training error set on failure, cleared on L0
// - Link training bit high during training
// - Slot clock bit from strap or load
// - Data link active follows DL_Active state
`timescale 1ns/1ns
module lcs_link_control_status #(
    parameter int WIDTH_W = 6
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Port identity and straps
    input  wire logic               isDownstream,
    input  wire logic               slotClkStrap,
    // Link training and data link layer status
    input  wire logic               trainActive,
    input  wire logic               trainFail,
    input  wire logic               trainDoneL0,
    input  wire logic [WIDTH_W-1:0] negWidth,
    input  wire logic               dlActive,
    // Controls to the link layers
    output logic      [1:0]         aspmCtl,
    output logic                    txL0sEnable,
    output logic                    txL1Enable,
    output logic                    rxL0sEnable,
    output logic                    linkDisable,
    output logic                    retrainPulse,
    output logic                    commonClk,
    output logic      [12:0]        ftsCount,
    output logic      [12:0]        ts1Count,
    // Interrupt
    output logic                    irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int IRQ_LOCAL = lcs_pkg::IRQ_W;

    logic                  wrStb;
    logic                  rdStb;
    logic [1:0]            aspm_r;
    logic                  linkDis_r;
    logic                  comClk_r;
    logic                  extSync_r;
    logic                  trnErr_r;
    logic                  slotClk_r;
    logic                  strapTaken_r;
    logic [IRQ_LOCAL-1:0]  irqStat_r;
    logic [IRQ_LOCAL-1:0]  irqStat_nxt;
    logic [IRQ_LOCAL-1:0]  irqMask_r;
    logic [IRQ_LOCAL-1:0]  irqEvt;
    logic                  dlActive_r;
    logic [31:0]           ctlStsWord;
    logic [31:0]           rdData;
    logic                  wrCtl;
    logic                  wrPortCfg;

    // Write of one byte lane of a word, used by every writable register.
    function automatic logic laneWr(input logic [3:0] sel, input int bitPos);
        laneWr = sel[bitPos/8];
    endfunction : laneWr

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    lcs_wb_slave u_wb (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_ack_o (wb_ack_o),
        .wrStb    (wrStb),
        .rdStb    (rdStb)
    );

    assign wrCtl     = wrStb && (wb_adr_i == lcs_pkg::ADDR_LINK_CTL_STS)
                       && laneWr(wb_sel_i, 0);
    assign wrPortCfg = wrStb && (wb_adr_i == lcs_pkg::ADDR_PORT_CFG)
                       && laneWr(wb_sel_i, 0);

    // ------------------------------------------------------------------
    // Link control
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aspm_r    <= lcs_pkg::ASPM_OFF;
            linkDis_r <= 1'b0;
            comClk_r  <= 1'b0;
            extSync_r <= 1'b0;
        end else if (wrCtl) begin
            aspm_r    <= wb_dat_i[lcs_pkg::ASPM_HI:lcs_pkg::ASPM_LO];
            linkDis_r <= wb_dat_i[lcs_pkg::LINK_DIS_BIT] & isDownstream;
            comClk_r  <= wb_dat_i[lcs_pkg::COM_CLK_BIT];
            extSync_r <= wb_dat_i[lcs_pkg::EXT_SYNC_BIT];
        end else if (!isDownstream) begin
            linkDis_r <= 1'b0;
        end
    end

    // Retrain is a strobe only; nothing is stored for readback.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            retrainPulse <= 1'b0;
        end else begin
            retrainPulse <= wrCtl && wb_dat_i[lcs_pkg::RETRAIN_BIT] && isDownstream;
        end
    end

    assign aspmCtl     = aspm_r;
    assign txL0sEnable = (aspm_r == lcs_pkg::ASPM_L0S) || (aspm_r == lcs_pkg::ASPM_BOTH);
    assign txL1Enable  = (aspm_r == lcs_pkg::ASPM_L1) || (aspm_r == lcs_pkg::ASPM_BOTH);
    assign rxL0sEnable = 1'b1;
    assign linkDisable = linkDis_r;
    assign commonClk   = comClk_r;
    assign ftsCount    = extSync_r ? lcs_pkg::FTS_EXT : lcs_pkg::FTS_NORMAL;
    assign ts1Count    = extSync_r ? lcs_pkg::TS1_EXT : lcs_pkg::TS1_NORMAL;

    // ------------------------------------------------------------------
    // Link status
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trnErr_r <= 1'b0;
        end else if (trainFail) begin
            trnErr_r <= 1'b1;
        end else if (trainDoneL0) begin
            trnErr_r <= 1'b0;
        end
    end

    // Strap is caught on the first clock after reset release; software may override it.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            slotClk_r    <= 1'b0;
            strapTaken_r <= 1'b0;
        end else if (!strapTaken_r) begin
            slotClk_r    <= slotClkStrap;
            strapTaken_r <= 1'b1;
        end else if (wrPortCfg) begin
            slotClk_r    <= wb_dat_i[0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dlActive_r <= 1'b0;
        end else begin
            dlActive_r <= dlActive;
        end
    end

    always_comb begin
        ctlStsWord = 32'h0000_0000;
        ctlStsWord[lcs_pkg::ASPM_HI:lcs_pkg::ASPM_LO] = aspm_r;
        ctlStsWord[lcs_pkg::RCB_BIT]      = 1'b0;
        ctlStsWord[lcs_pkg::LINK_DIS_BIT] = linkDis_r;
        ctlStsWord[lcs_pkg::RETRAIN_BIT]  = 1'b0;
        ctlStsWord[lcs_pkg::COM_CLK_BIT]  = comClk_r;
        ctlStsWord[lcs_pkg::EXT_SYNC_BIT] = extSync_r;
        ctlStsWord[lcs_pkg::SPEED_HI:lcs_pkg::SPEED_LO] = lcs_pkg::SPEED_2G5;
        ctlStsWord[lcs_pkg::WIDTH_HI:lcs_pkg::WIDTH_LO] = 6'(negWidth);
        ctlStsWord[lcs_pkg::TRN_ERR_BIT]  = trnErr_r;
        ctlStsWord[lcs_pkg::TRAINING_BIT] = trainActive;
        ctlStsWord[lcs_pkg::SLOT_CLK_BIT] = slotClk_r;
        ctlStsWord[lcs_pkg::DL_ACT_BIT]   = dlActive;
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_comb begin
        irqEvt = '0;
        irqEvt[lcs_pkg::IRQ_TRN_DONE] = trainDoneL0;
        irqEvt[lcs_pkg::IRQ_TRN_ERR]  = trainFail;
        irqEvt[lcs_pkg::IRQ_DL_UP]    = dlActive & ~dlActive_r;
        irqEvt[lcs_pkg::IRQ_DL_DOWN]  = ~dlActive & dlActive_r;
    end

    // A read of the status clears it, but an event in the same cycle stays set.
    always_comb begin
        irqStat_nxt = irqStat_r;
        if (rdStb && (wb_adr_i == lcs_pkg::ADDR_IRQ_STATUS)) begin
            irqStat_nxt = '0;
        end
        irqStat_nxt = irqStat_nxt | irqEvt;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqStat_r <= '0;
        end else begin
            irqStat_r <= irqStat_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqMask_r <= '0;
        end else if (wrStb && (wb_adr_i == lcs_pkg::ADDR_IRQ_MASK) && laneWr(wb_sel_i, 0)) begin
            irqMask_r <= wb_dat_i[IRQ_LOCAL-1:0];
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rdData = 32'h0000_0000;
        if (wb_adr_i == lcs_pkg::ADDR_LINK_CTL_STS) begin
            rdData = ctlStsWord;
        end else if (wb_adr_i == lcs_pkg::ADDR_IRQ_STATUS) begin
            rdData[IRQ_LOCAL-1:0] = irqStat_r;
        end else if (wb_adr_i == lcs_pkg::ADDR_IRQ_MASK) begin
            rdData[IRQ_LOCAL-1:0] = irqMask_r;
        end else if (wb_adr_i == lcs_pkg::ADDR_PORT_CFG) begin
            rdData[0] = slotClk_r;
            rdData[1] = isDownstream;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rdStb) begin
            wb_dat_o <= rdData;
        end
    end

endmodule : lcs_link_control_status

// ### dv/lcs_link_asserts.sv
// Concurrent checks on the ports of the link control and status block.
`timescale 1ns/1ns
module lcs_link_asserts #(
    parameter int WIDTH_W = 6
) (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rst,
    // Wishbone
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    // Link side
    input wire logic               isDownstream,
    input wire logic               trainActive,
    input wire logic [WIDTH_W-1:0] negWidth,
    input wire logic               dlActive,
    input wire logic [1:0]         aspmCtl,
    input wire logic               txL0sEnable,
    input wire logic               txL1Enable,
    input wire logic               rxL0sEnable,
    input wire logic               linkDisable,
    input wire logic               retrainPulse,
    input wire logic [12:0]        ftsCount,
    input wire logic [12:0]        ts1Count
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_ctl;
        s_req ##0 (!wb_we_i && wb_adr_i == lcs_pkg::ADDR_LINK_CTL_STS);
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_one_cycle: assert property (s_req |=> s_ack_pulse) else $error("ack timing wrong");
    a_aspm_tx_decode: assert property (
        txL0sEnable == aspmCtl[0] && txL1Enable == aspmCtl[1])
        else $error("aspm decode wrong");
    a_rx_l0s_on: assert property (rxL0sEnable) else $error("rx L0s not allowed");
    a_upstream_no_disable: assert property (!isDownstream |-> !linkDisable)
        else $error("link disable on upstream");
    a_retrain_cause: assert property (
        retrainPulse |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_dat_i[lcs_pkg::RETRAIN_BIT] && isDownstream
        && wb_adr_i == lcs_pkg::ADDR_LINK_CTL_STS))
        else $error("retrain pulse without request");
    a_retrain_single: assert property (retrainPulse |=> !retrainPulse)
        else $error("retrain pulse too long");
    a_ext_sync_pair: assert property (
        (ftsCount == lcs_pkg::FTS_EXT) == (ts1Count == lcs_pkg::TS1_EXT)
        && (ftsCount == lcs_pkg::FTS_EXT || ftsCount == lcs_pkg::FTS_NORMAL))
        else $error("sync counts wrong");
    a_rd_fixed_bits: assert property (
        s_rd_ctl |=> wb_dat_o[19:16] == 4'h1 && !wb_dat_o[3] && !wb_dat_o[5])
        else $error("fixed control bits wrong");
    a_rd_width_live: assert property (
        s_rd_ctl |=> wb_dat_o[25:20] == $past(negWidth))
        else $error("width not reported");
    a_rd_training: assert property (
        s_rd_ctl |=> wb_dat_o[27] == $past(trainActive))
        else $error("training bit wrong");
    a_rd_dl_active: assert property (
        s_rd_ctl |=> wb_dat_o[29] == $past(dlActive))
        else $error("data link active wrong");
endmodule : lcs_link_asserts

bind lcs_link_control_status lcs_link_asserts #(.WIDTH_W(WIDTH_W)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .isDownstream(isDownstream),
    .trainActive(trainActive), .negWidth(negWidth), .dlActive(dlActive),
    .aspmCtl(aspmCtl), .txL0sEnable(txL0sEnable), .txL1Enable(txL1Enable),
    .rxL0sEnable(rxL0sEnable), .linkDisable(linkDisable), .retrainPulse(retrainPulse),
    .ftsCount(ftsCount), .ts1Count(ts1Count));

// ### dv/tb_top.sv
// Register-level testbench of the link control and status block.
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] wdat = 0, rdat, dato, d;
    logic ack, isDown = 1, strap = 1, tAct = 0, tFail = 0, tDone = 0, dlAct = 0;
    logic [5:0]  width = 6'h01;
    logic [1:0]  aspm;
    logic txS, txL, rxS, lDis, rtr, cClk, irq;
    logic [12:0] fts, ts1;
    int miscompares = 0, comparisons = 0;

    lcs_link_control_status dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dato), .wb_ack_o(ack), .isDownstream(isDown), .slotClkStrap(strap),
        .trainActive(tAct), .trainFail(tFail), .trainDoneL0(tDone), .negWidth(width),
        .dlActive(dlAct), .aspmCtl(aspm), .txL0sEnable(txS), .txL1Enable(txL),
        .rxL0sEnable(rxS), .linkDisable(lDis), .retrainPulse(rtr), .commonClk(cClk),
        .ftsCount(fts), .ts1Count(ts1), .irq(irq));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task close_out();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check32

    // One classic cycle; read data is taken at the edge where ack is sampled.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= v; sel <= s;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) check32("ack", 32'h1, 32'h0);
        rdat = dato;
        cyc <= 0; stb <= 0; we <= 0;
    endtask : bus

    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check32(name, exp, rdat);
    endtask : rd_chk

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        rd_chk("ctl_reset", 8'hf0, 32'h1011_0000);
        check32("counts", {6'h0, fts, ts1}, {6'h0, 13'h00ff, 13'h0010});
        check32("irq_reset", 32'h0, {31'h0, irq});
        for (int i = 0; i < 4; i++) begin
            d = 32'hffff_ff00 | i | (i << 6) | ((i == 3) ? 32'h38 : 32'h0);
            bus(1'b1, 8'hf0, d, 4'hf);
            rd_chk("ctl_rw", 8'hf0, {16'h1011, 8'h0, d[7:6], 1'b0, d[4], 2'b0, d[1:0]});
            check32("outs", {aspm, cClk, lDis, fts}, {d[1:0], d[6], d[4], d[7] ? 13'h1000 : 13'h00ff});
            check32("ts1", {19'h0, ts1}, {19'h0, d[7] ? 13'h0400 : 13'h0010});
        end
        bus(1'b1, 8'hf0, 32'h0000_00c0, 4'he);
        rd_chk("sel_drop", 8'hf0, 32'h1011_00d3);
        bus(1'b1, 8'hf0, 32'h0, 4'hf);
        isDown <= 0;
        bus(1'b1, 8'hf0, 32'h0000_0030, 4'hf);
        rd_chk("upstream", 8'hf0, 32'h1011_0000);
        rd_chk("port_cfg", 8'he8, 32'h1);
        isDown <= 1;
        bus(1'b1, 8'he8, 32'h0, 4'hf);
        rd_chk("port_cfg_wr", 8'he8, 32'h2);
        bus(1'b1, 8'he8, 32'h1, 4'hf);
        rd_chk("port_cfg_back", 8'he8, 32'h3);
        tAct <= 1; width <= 6'h04; dlAct <= 1;
        rd_chk("status_live", 8'hf0, 32'h3841_0000);
        @(posedge clk_sys) tFail <= 1;
        @(posedge clk_sys) tFail <= 0;
        rd_chk("train_err", 8'hf0, 32'h3c41_0000);
        tAct <= 0;
        @(posedge clk_sys) tDone <= 1;
        @(posedge clk_sys) tDone <= 0;
        rd_chk("train_ok", 8'hf0, 32'h3041_0000);
        rd_chk("irq_sts", 8'hf8, 32'h7);
        bus(1'b1, 8'hfc, 32'h2, 4'hf);
        rd_chk("irq_mask", 8'hfc, 32'h2);
        @(posedge clk_sys) tFail <= 1;
        @(posedge clk_sys) tFail <= 0;
        @(posedge clk_sys);
        check32("irq_on", 32'h1, {31'h0, irq});
        rd_chk("irq_fail", 8'hf8, 32'h2);
        check32("irq_off", 32'h0, {31'h0, irq});
        dlAct <= 0;
        @(posedge clk_sys) tDone <= 1;
        @(posedge clk_sys) tDone <= 0;
        repeat (3) @(posedge clk_sys);
        check32("irq_masked", 32'h0, {31'h0, irq});
        rd_chk("irq_down", 8'hf8, 32'h9);
        bus(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
        rd_chk("unmapped", 8'h40, 32'h0);
        check32("rx_l0s", 32'h1, {31'h0, rxS});
        close_out();
    end
endmodule : tb_top
